/* rtl/imu_setup_defines.svh */
// constants for the inertial unit setup command decoder
// assumes byte-wide message traffic; included by bare name
`ifndef IMU_SETUP_DEFINES_SVH
`define IMU_SETUP_DEFINES_SVH
// message header values
`define IMU_ADDR_IMU 8'hE6
`define IMU_ADDR_ALL 8'hFF
`define IMU_CAT_SETUP 8'h35
// function codes
`define IMU_FN_YAW_CAL 8'h03
`define IMU_FN_BANK_CAL 8'h04
`define IMU_FN_PITCH_CAL 8'h05
`define IMU_FN_FORMAT 8'h06
`define IMU_FN_INTEG_CLR 8'h07
`define IMU_FN_GYRO_BIAS 8'h08
`define IMU_FN_BUMP 8'h09
`define IMU_FN_NV_DUMP 8'h0A
`define IMU_FN_TEMP_COMP 8'h0B
`define IMU_FN_HORIZON 8'h0C
`define IMU_FN_X1G 8'h0D
`define IMU_FN_Y1G 8'h0E
`define IMU_FN_INCL 8'h0F
`define IMU_FN_SLEW 8'h10
`define IMU_FN_MODE 8'h11
// message lengths
`define IMU_LEN_SHORT 8'h02
`define IMU_LEN_BYTE 8'h03
`define IMU_LEN_WORD 8'h04
// payload values
`define IMU_BIAS_KEY0 8'h55
`define IMU_BIAS_KEY1 8'hAA
`define IMU_FMT_MIN 8'h01
`define IMU_FMT_MAX 8'h04
`define IMU_FMT_CAL 8'h03
`define IMU_FMT_DEFAULT 3'h1
`define IMU_MODE_MAX 8'h01
// reply layout
`define IMU_ACK_LEN 8'h02
`define IMU_ACK_TYPE 8'h0A
`define IMU_DUMP_LEN 8'h38
`define IMU_DUMP_TYPE 8'h54
`define IMU_DUMP_HDR 8'h03
`define IMU_ACK_LAST 8'h03
`define IMU_DUMP_LAST 8'h39
// reset values
`define IMU_WORD_RST 16'h0000
`endif

/* rtl/imu_setup_pkg.sv */
// types shared by the setup command decoder files
// no constants live here; numbers sit in the defines header
package imu_setup_pkg;
    typedef enum logic [1:0] {
        REPLY_IDLE = 2'b00,
        REPLY_SEND = 2'b01
    } reply_state_t;
    typedef enum logic {
        KIND_ACK = 1'b0,
        KIND_DUMP = 1'b1
    } reply_kind_t;
endpackage

/* rtl/frame_collector.sv */
// gathers one message from the byte stream into header and payload fields
// assumes rx_first marks the address byte and rx_last the final byte
`timescale 1ns/1ps
`include "imu_setup_defines.svh"
module frame_collector (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // byte stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_first,
    input wire logic rx_last,
    // collected message
    output logic done_q,
    output logic len_ok_q,
    output logic [7:0] addr_q,
    output logic [7:0] len_q,
    output logic [7:0] cat_q,
    output logic [7:0] fn_q,
    output logic [7:0] p0_q,
    output logic [7:0] p1_q
);
    logic [7:0] cnt_q;
    logic in_msg_q;
    logic [7:0] pos;
    logic take;

    // position of the current byte; a first byte always restarts
    assign pos = rx_first ? 8'h00 : cnt_q;
    assign take = rx_valid && (rx_first || in_msg_q);

    // byte counter saturates so long junk never wraps into a valid length
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= 8'h00;
            in_msg_q <= 1'b0;
        end
        else if (take)
        begin
            cnt_q <= (pos == 8'hFF) ? pos : pos + 8'h01;
            in_msg_q <= !rx_last;
        end
    end

    // field capture by position
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            addr_q <= 8'h00;
            len_q <= 8'h00;
            cat_q <= 8'h00;
            fn_q <= 8'h00;
            p0_q <= 8'h00;
            p1_q <= 8'h00;
        end
        else if (take)
        begin
            if (pos == 8'h00)
                addr_q <= rx_data;
            else if (pos == 8'h01)
                len_q <= rx_data;
            else if (pos == 8'h02)
                cat_q <= rx_data;
            else if (pos == 8'h03)
                fn_q <= rx_data;
            else if (pos == 8'h04)
                p0_q <= rx_data;
            else if (pos == 8'h05)
                p1_q <= rx_data;
        end
    end

    // end of message: length byte must count everything after it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            done_q <= 1'b0;
            len_ok_q <= 1'b0;
        end
        else
        begin
            done_q <= take && rx_last;
            len_ok_q <= take && rx_last && (pos >= 8'h02) && (len_q == pos - 8'h01);
        end
    end
endmodule

/* rtl/reply_sender.sv */
// sends the acknowledge or the calibration dump reply byte by byte
// assumes the calibration store answers nv_rd_addr combinationally
`timescale 1ns/1ps
`include "imu_setup_defines.svh"
module reply_sender (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // requests
    input wire logic start_ack,
    input wire logic start_dump,
    output logic busy,
    // calibration store read
    output logic [7:0] nv_rd_addr_q,
    input wire logic [7:0] nv_rd_data,
    // reply stream
    input wire logic tx_ready,
    output logic tx_valid_q,
    output logic [7:0] tx_data_q,
    output logic tx_last_q
);
    imu_setup_pkg::reply_state_t state_q;
    imu_setup_pkg::reply_kind_t kind_q;
    logic [7:0] idx_q;
    logic [7:0] last_idx;
    logic [7:0] next_byte;

    assign busy = (state_q != imu_setup_pkg::REPLY_IDLE);
    assign last_idx = (kind_q == imu_setup_pkg::KIND_DUMP) ? `IMU_DUMP_LAST : `IMU_ACK_LAST;

    // byte at the current index; ack body and dump header share position 0
    always_comb
    begin
        next_byte = 8'h00;
        if (idx_q == 8'h00)
            next_byte = `IMU_ADDR_ALL;
        else if (kind_q == imu_setup_pkg::KIND_ACK)
        begin
            if (idx_q == 8'h01)
                next_byte = `IMU_ACK_LEN;
            else if (idx_q == 8'h02)
                next_byte = `IMU_ACK_TYPE;
        end
        else if (idx_q == 8'h01)
            next_byte = `IMU_DUMP_LEN;
        else if (idx_q == 8'h02)
            next_byte = `IMU_DUMP_TYPE;
        else
            next_byte = nv_rd_data;
    end

    // a new request while busy is dropped; the caller does not check busy
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= imu_setup_pkg::REPLY_IDLE;
            kind_q <= imu_setup_pkg::KIND_ACK;
            idx_q <= 8'h00;
            nv_rd_addr_q <= 8'h00;
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
            tx_last_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                imu_setup_pkg::REPLY_IDLE:
                begin
                    if (start_ack || start_dump)
                    begin
                        state_q <= imu_setup_pkg::REPLY_SEND;
                        kind_q <= start_dump ? imu_setup_pkg::KIND_DUMP
                                             : imu_setup_pkg::KIND_ACK;
                        idx_q <= 8'h00;
                        nv_rd_addr_q <= 8'h00;
                    end
                end
                imu_setup_pkg::REPLY_SEND:
                begin
                    if (!tx_valid_q || tx_ready)
                    begin
                        if (idx_q <= last_idx)
                        begin
                            tx_valid_q <= 1'b1;
                            tx_data_q <= next_byte;
                            tx_last_q <= (idx_q == last_idx);
                            idx_q <= idx_q + 8'h01;
                            // store index trails the byte index by the header length
                            nv_rd_addr_q <= (idx_q >= `IMU_DUMP_HDR - 8'h01)
                                            ? idx_q + 8'h01 - `IMU_DUMP_HDR : 8'h00;
                        end
                        else
                        begin
                            tx_valid_q <= 1'b0;
                            tx_last_q <= 1'b0;
                            state_q <= imu_setup_pkg::REPLY_IDLE;
                        end
                    end
                end
                default:
                    state_q <= imu_setup_pkg::REPLY_IDLE;
            endcase
        end
    end
endmodule

/* rtl/imu_setup_command_decoder.sv */
// top of the inertial unit setup command decoder
// assumes a byte stream already framed by rx_first and rx_last
// What this block does
// - yaw rate factor word is taken only in calibration mode, category 53 function 3.
// - format 3 is flagged so the yaw accumulator is reported to the host.
// - bank rate factor, function 4, taken only in calibration mode.
// - pitch rate factor taken only in calibration mode, same encoding.
// - format command is function 6, length 4, value 1 to 4 twice.
// - format 3 is never made persistent; boot restores a saved format of 1, 2 or 4.
// - choosing format 3 enters calibration mode.
// - function 7 length 2 clears the three integrators and acknowledges.
// - function 8 in calibration mode needs 55h then AAh, then captures bias.
// - function 9 loads the 16-bit bump factor.
// - function 10 sends the calibration store dump instead of an acknowledge.
// - function 11 sets temperature compensation, calibration mode only.
// - function 12 resets the horizon to gravity, then acknowledges.
// - function 13 captures X 1G and Z zero points, then acknowledges.
// - function 14 captures the Y 1G point, then acknowledges.
// - function 15 captures inclination on the compass variant only.
// - function 16 loads the 16-bit slew factor.
// - mode byte 0 inertial, 1 magnetometer, compass variant only.
// - accepted commands without data reply get FF 02 0A 00.
`timescale 1ns/1ps
`include "imu_setup_defines.svh"
module imu_setup_command_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // received message bytes
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_first,
    input wire logic rx_last,
    // reply bytes
    input wire logic tx_ready,
    output logic tx_valid_q,
    output logic [7:0] tx_data_q,
    output logic tx_last_q,
    // calibration nonvolatile store read port
    output logic [7:0] nv_rd_addr_q,
    input wire logic [7:0] nv_rd_data,
    // variant and saved format
    input wire logic compass_variant,
    input wire logic [7:0] saved_format,
    // format and mode state
    output logic [2:0] out_format_q,
    output logic cal_mode_q,
    output logic yaw_report_q,
    output logic [2:0] persist_format_q,
    output logic persist_we_q,
    output logic att_mag_mode_q,
    // rate factors, index 0 yaw, 1 bank, 2 pitch
    output logic [15:0] rate_factor_q [3],
    output logic [2:0] rate_load_q,
    // bump and slew adjustment_factor_word values
    output logic [15:0] bump_factor_q,
    output logic bump_load_q,
    output logic [15:0] slew_factor_q,
    output logic slew_load_q,
    // one-cycle action strobes
    output logic integ_clear_q,
    output logic bias_capture_q,
    output logic temp_comp_q,
    output logic horizon_set_q,
    output logic x1g_capture_q,
    output logic y1g_capture_q,
    output logic incl_capture_q
);
    logic done;
    logic len_ok;
    logic [7:0] addr;
    logic [7:0] len;
    logic [7:0] cat;
    logic [7:0] fn;
    logic [7:0] p0;
    logic [7:0] p1;
    logic reply_busy;
    logic boot_q;
    logic ours;
    logic allowed;
    logic payload_ok;
    logic cmd_ok;
    logic start_ack;
    logic start_dump;
    logic [15:0] word;
    logic [2:0] fmt_new;
    logic fmt_ok;

    // expected length byte for each function, zero when unknown
    function automatic logic [7:0] expected_len(input logic [7:0] code);
        if (code == `IMU_FN_YAW_CAL || code == `IMU_FN_BANK_CAL || code == `IMU_FN_PITCH_CAL)
            expected_len = `IMU_LEN_WORD;
        else if (code == `IMU_FN_FORMAT || code == `IMU_FN_GYRO_BIAS)
            expected_len = `IMU_LEN_WORD;
        else if (code == `IMU_FN_BUMP || code == `IMU_FN_SLEW)
            expected_len = `IMU_LEN_WORD;
        else if (code == `IMU_FN_MODE)
            expected_len = `IMU_LEN_BYTE;
        else if (code >= `IMU_FN_INTEG_CLR && code <= `IMU_FN_INCL)
            expected_len = `IMU_LEN_SHORT;
        else
            expected_len = 8'h00;
    endfunction

    // functions refused unless the unit sits in calibration mode
    function automatic logic cal_only(input logic [7:0] code);
        cal_only = (code == `IMU_FN_YAW_CAL) || (code == `IMU_FN_BANK_CAL) ||
                   (code == `IMU_FN_PITCH_CAL) || (code == `IMU_FN_GYRO_BIAS) ||
                   (code == `IMU_FN_TEMP_COMP);
    endfunction

    // a format value worth keeping, used for commands and the saved format
    function automatic logic format_valid(input logic [7:0] v);
        format_valid = (v >= `IMU_FMT_MIN) && (v <= `IMU_FMT_MAX);
    endfunction

    frame_collector frame_collector_i (
        .clk(clk),
        .rst_n(rst_n),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_first(rx_first),
        .rx_last(rx_last),
        .done_q(done),
        .len_ok_q(len_ok),
        .addr_q(addr),
        .len_q(len),
        .cat_q(cat),
        .fn_q(fn),
        .p0_q(p0),
        .p1_q(p1)
    );

    // command qualification: address, category, length, mode gate, payload
    assign word = {p1, p0};
    assign fmt_new = p0[2:0];
    assign fmt_ok = (p0 == p1) && format_valid(p0);
    assign ours = done && len_ok && (addr == `IMU_ADDR_IMU) && (cat == `IMU_CAT_SETUP);
    assign allowed = !cal_only(fn) || cal_mode_q;
    always_comb
    begin
        payload_ok = 1'b1;
        if (fn == `IMU_FN_FORMAT)
            payload_ok = fmt_ok;
        else if (fn == `IMU_FN_GYRO_BIAS)
            payload_ok = (p0 == `IMU_BIAS_KEY0) && (p1 == `IMU_BIAS_KEY1);
        else if (fn == `IMU_FN_MODE)
            payload_ok = compass_variant && (p0 <= `IMU_MODE_MAX);
        else if (fn == `IMU_FN_INCL)
            payload_ok = compass_variant;
    end
    // the boot cycle ignores commands so the saved format load is not raced
    assign cmd_ok = ours && !boot_q && (len == expected_len(fn)) && allowed && payload_ok;
    assign start_dump = cmd_ok && (fn == `IMU_FN_NV_DUMP);
    assign start_ack = cmd_ok && (fn != `IMU_FN_NV_DUMP);

    reply_sender reply_sender_i (
        .clk(clk),
        .rst_n(rst_n),
        .start_ack(start_ack),
        .start_dump(start_dump),
        .busy(reply_busy),
        .nv_rd_addr_q(nv_rd_addr_q),
        .nv_rd_data(nv_rd_data),
        .tx_ready(tx_ready),
        .tx_valid_q(tx_valid_q),
        .tx_data_q(tx_data_q),
        .tx_last_q(tx_last_q)
    );

    // format and calibration mode; format 3 lives only until power loss
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            boot_q <= 1'b1;
            out_format_q <= `IMU_FMT_DEFAULT;
            cal_mode_q <= 1'b0;
            yaw_report_q <= 1'b0;
            persist_format_q <= `IMU_FMT_DEFAULT;
            persist_we_q <= 1'b0;
        end
        else
        begin
            boot_q <= 1'b0;
            persist_we_q <= 1'b0;
            if (boot_q)
            begin
                // saved format is caught after release, never format 3
                if (format_valid(saved_format) && saved_format != `IMU_FMT_CAL)
                begin
                    out_format_q <= saved_format[2:0];
                    persist_format_q <= saved_format[2:0];
                end
            end
            else if (cmd_ok && fn == `IMU_FN_FORMAT)
            begin
                out_format_q <= fmt_new;
                cal_mode_q <= (p0 == `IMU_FMT_CAL);
                yaw_report_q <= (p0 == `IMU_FMT_CAL);
                if (p0 != `IMU_FMT_CAL)
                begin
                    persist_format_q <= fmt_new;
                    persist_we_q <= 1'b1;
                end
            end
        end
    end

    // rate factor words, one per axis, calibration mode only
    genvar ax;
    generate
        for (ax = 0; ax < 3; ax++)
        begin : g_rate
            localparam logic [7:0] AXIS_FN = `IMU_FN_YAW_CAL + 8'(ax);
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    rate_factor_q[ax] <= `IMU_WORD_RST;
                    rate_load_q[ax] <= 1'b0;
                end
                else
                begin
                    rate_load_q[ax] <= cmd_ok && (fn == AXIS_FN);
                    if (cmd_ok && fn == AXIS_FN)
                        rate_factor_q[ax] <= word;
                end
            end
        end
    endgenerate

    // bump and slew factors; any 16-bit value is taken as given
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bump_factor_q <= `IMU_WORD_RST;
            slew_factor_q <= `IMU_WORD_RST;
            bump_load_q <= 1'b0;
            slew_load_q <= 1'b0;
        end
        else
        begin
            bump_load_q <= cmd_ok && (fn == `IMU_FN_BUMP);
            slew_load_q <= cmd_ok && (fn == `IMU_FN_SLEW);
            if (cmd_ok && fn == `IMU_FN_BUMP)
                bump_factor_q <= word;
            if (cmd_ok && fn == `IMU_FN_SLEW)
                slew_factor_q <= word;
        end
    end

    // attitude mode select, only meaningful on the compass variant
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            att_mag_mode_q <= 1'b0;
        else if (cmd_ok && fn == `IMU_FN_MODE)
            att_mag_mode_q <= p0[0];
    end

    // one-cycle action strobes to the sensing core
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            integ_clear_q <= 1'b0;
            bias_capture_q <= 1'b0;
            temp_comp_q <= 1'b0;
            horizon_set_q <= 1'b0;
            x1g_capture_q <= 1'b0;
            y1g_capture_q <= 1'b0;
            incl_capture_q <= 1'b0;
        end
        else
        begin
            integ_clear_q <= cmd_ok && (fn == `IMU_FN_INTEG_CLR);
            bias_capture_q <= cmd_ok && (fn == `IMU_FN_GYRO_BIAS);
            temp_comp_q <= cmd_ok && (fn == `IMU_FN_TEMP_COMP);
            horizon_set_q <= cmd_ok && (fn == `IMU_FN_HORIZON);
            x1g_capture_q <= cmd_ok && (fn == `IMU_FN_X1G);
            y1g_capture_q <= cmd_ok && (fn == `IMU_FN_Y1G);
            incl_capture_q <= cmd_ok && (fn == `IMU_FN_INCL);
        end
    end

    // reply checks only run when the host takes every byte, since a stall holds a byte
    sequence s_reply_head;
        tx_valid_q && tx_data_q == `IMU_ADDR_ALL && tx_ready;
    endsequence
    sequence s_ack_tail;
        tx_data_q == 8'h00 && tx_last_q && $past(tx_data_q) == `IMU_ACK_TYPE
            && $past(tx_data_q, 2) == `IMU_ACK_LEN && $past(tx_data_q, 3) == `IMU_ADDR_ALL
            && $past(tx_valid_q, 3);
    endsequence
    sequence s_clear_taken;
        integ_clear_q && !$past(reply_busy) ##1 tx_ready [*3];
    endsequence

    a_yaw_cal_gate: assert property (@(posedge clk) disable iff (!rst_n)
        rate_load_q[0] |-> $past(cal_mode_q) && $past(fn) == `IMU_FN_YAW_CAL)
        else $error("yaw factor loaded outside calibration mode");
    a_bank_cal_gate: assert property (@(posedge clk) disable iff (!rst_n)
        rate_load_q[1] |-> $past(cal_mode_q) && rate_factor_q[1] == $past(word))
        else $error("bank factor load wrong");
    a_bias_key_check: assert property (@(posedge clk) disable iff (!rst_n)
        bias_capture_q |-> $past(cal_mode_q) && $past(p0) == `IMU_BIAS_KEY0
            && $past(p1) == `IMU_BIAS_KEY1)
        else $error("bias capture without key or mode");
    a_fmt3_enters_cal: assert property (@(posedge clk) disable iff (!rst_n)
        $past(cmd_ok) && $past(fn) == `IMU_FN_FORMAT && $past(p0) == `IMU_FMT_CAL
            |-> cal_mode_q && yaw_report_q && out_format_q == 3'h3)
        else $error("format 3 did not enter calibration mode");
    a_persist_never3: assert property (@(posedge clk) disable iff (!rst_n)
        persist_we_q |-> persist_format_q != 3'h3 && persist_format_q == out_format_q)
        else $error("format 3 made persistent");
    a_fmt_reject_bad: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(boot_q) && out_format_q != $past(out_format_q)
            |-> $past(p0) == $past(p1) && $past(done))
        else $error("format changed by a bad command");
    a_len_mismatch: assert property (@(posedge clk) disable iff (!rst_n)
        (integ_clear_q || horizon_set_q || bump_load_q || slew_load_q) |-> $past(len_ok))
        else $error("action taken on a length mismatch");
    a_ack_after_clear: assert property (@(posedge clk) disable iff (!rst_n)
        s_clear_taken |-> ##1 s_ack_tail)
        else $error("integrator clear not acknowledged");
    a_dump_not_ack: assert property (@(posedge clk) disable iff (!rst_n)
        start_dump && !reply_busy ##2 tx_ready |-> s_reply_head
            ##1 tx_data_q == `IMU_DUMP_LEN)
        else $error("dump request answered with wrong header");
    a_bump_word_load: assert property (@(posedge clk) disable iff (!rst_n)
        bump_load_q |-> bump_factor_q == {$past(p1), $past(p0)})
        else $error("bump factor not loaded from payload");
    a_mode_variant: assert property (@(posedge clk) disable iff (!rst_n)
        att_mag_mode_q != $past(att_mag_mode_q) |-> $past(compass_variant))
        else $error("mode changed on the basic variant");
endmodule

/* verif/host_link_model.sv */
// host side model: sends command bytes, takes reply bytes, serves the store
// assumes one clock; bytes change at the falling edge
`timescale 1ns/1ps
module host_link_model (
    // clock
    input wire logic clk,
    // command stream
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_first,
    output logic rx_last,
    // reply stream
    output logic tx_ready,
    input wire logic tx_valid_q,
    input wire logic [7:0] tx_data_q,
    // store read
    input wire logic [7:0] nv_rd_addr_q,
    output logic [7:0] nv_rd_data
);
    logic [7:0] rx_q [$];
    initial {rx_valid, rx_data, rx_first, rx_last, tx_ready} = 12'h001;
    // store pattern tied to the address so a wrong index shows
    assign nv_rd_data = nv_rd_addr_q ^ 8'h5A;
    // reply bytes; ready stalls at random so held bytes get exercised
    always @(posedge clk) if (tx_valid_q && tx_ready) rx_q.push_back(tx_data_q);
    always @(negedge clk) tx_ready <= ($urandom_range(0, 3) != 0);
    // one whole message; idle data is inverted so stale bytes cannot match
    task automatic send(input logic [7:0] m [$]);
        foreach (m[i])
        begin
            @(negedge clk);
            {rx_valid, rx_first, rx_last} = {1'b1, i == 0, i == m.size() - 1};
            rx_data = m[i];
        end
        @(negedge clk);
        {rx_valid, rx_first, rx_last} = 3'h0;
        rx_data = ~rx_data;
    endtask
endmodule

/* verif/imu_setup_command_decoder_tb.sv */
// self-checking bench for the setup command decoder
// assumes the host model in host_link_model.sv
`timescale 1ns/1ps
module imu_setup_command_decoder_tb;
    logic clk, rst_n, rx_valid, rx_first, rx_last, tx_ready, tx_valid_q, tx_last_q;
    logic [7:0] rx_data, tx_data_q, nv_rd_addr_q, nv_rd_data, seen;
    logic compass_variant = 1'b1;
    logic [7:0] saved_format = 8'h02;
    logic [2:0] out_format_q, persist_format_q, rate_load_q;
    logic cal_mode_q, yaw_report_q, persist_we_q, att_mag_mode_q, bump_load_q, slew_load_q;
    logic integ_clear_q, bias_capture_q, temp_comp_q, horizon_set_q;
    logic x1g_capture_q, y1g_capture_q, incl_capture_q;
    logic [15:0] rate_factor_q [3];
    logic [15:0] bump_factor_q, slew_factor_q, w;
    logic [7:0] fl [6] = '{8'h07, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
    int bl [6] = '{1, 3, 4, 5, 6, 7};
    int error_cnt = 0, total_checks = 0, acc;
    imu_setup_command_decoder imu_setup_command_decoder_i (.*);
    host_link_model host_link_model_i (.*);
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // sticky record of the one-cycle strobes
    always @(posedge clk) seen <= seen | {incl_capture_q, y1g_capture_q, x1g_capture_q,
        horizon_set_q, temp_comp_q, bias_capture_q, integ_clear_q, persist_we_q};
    function automatic logic [15:0] cal_word(input int a);
        int m = (a < 0) ? -a : a;
        cal_word = 16'(1179648000 / (m / 20)) | ((a < 0) ? 16'h8000 : 16'h0000);
    endfunction
    task automatic chk(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] fn, len, input int n, input logic [15:0] p);
        logic [7:0] m [$];
        m = {8'hE6, len, 8'h35, fn};
        if (n > 0) m.push_back(p[7:0]);
        if (n > 1) m.push_back(p[15:8]);
        seen = 8'h00;
        host_link_model_i.rx_q.delete();
        host_link_model_i.send(m);
        repeat (250) @(negedge clk);
        $display("test fn %h done", fn);
    endtask
    task automatic ack_chk();
        chk(host_link_model_i.rx_q.size(), 4);
        chk({host_link_model_i.rx_q[0], host_link_model_i.rx_q[1]}, 16'hFF02);
        chk({host_link_model_i.rx_q[2], host_link_model_i.rx_q[3]}, 16'h0A00);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // watchdog sized well above the 25 or so commands of 260 cycles each
    initial
    begin
        #250000;
        error_cnt++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(73316));
        rst_n = 1'b0;
        seen = 8'h00;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(out_format_q, 16'h2);
        cmd(8'h03, 8'h04, 2, 16'h1234);
        chk(rate_factor_q[0], 16'h0);
        cmd(8'h06, 8'h04, 2, 16'h0303);
        chk({out_format_q, cal_mode_q, yaw_report_q}, 16'h000F);
        ack_chk();
        for (int k = 0; k < 3; k++)
        begin
            acc = $urandom_range(800000, 4000000);
            w = cal_word((k == 1) ? -acc : acc);
            cmd(8'h07, 8'h02, 0, 16'h0);
            cmd(8'h03 + 8'(k), 8'h04, 2, w);
            chk(rate_factor_q[k], w);
        end
        w = 16'($urandom_range(50, 500));
        cmd(8'h09, 8'h04, 2, w);
        chk(bump_factor_q, w);
        cmd(8'h10, 8'h04, 2, ~w);
        chk(slew_factor_q, ~w);
        cmd(8'h09, 8'h03, 2, 16'h0777);
        chk(bump_factor_q, w);
        cmd(8'h06, 8'h04, 2, 16'h0402);
        chk(out_format_q, 16'h3);
        cmd(8'h08, 8'h04, 2, 16'hAA55);
        chk(seen, 16'h04);
        foreach (fl[i])
        begin
            cmd(fl[i], 8'h02, 0, 16'h0);
            chk(seen, 16'h1 << bl[i]);
            ack_chk();
        end
        cmd(8'h11, 8'h03, 1, 16'h1);
        chk(att_mag_mode_q, 16'h1);
        compass_variant = 1'b0;
        cmd(8'h11, 8'h03, 1, 16'h0);
        chk(att_mag_mode_q, 16'h1);
        cmd(8'h0F, 8'h02, 0, 16'h0);
        chk({seen, 8'(host_link_model_i.rx_q.size())}, 16'h0);
        compass_variant = 1'b1;
        cmd(8'h0A, 8'h02, 0, 16'h0);
        chk(host_link_model_i.rx_q.size(), 58);
        chk({host_link_model_i.rx_q[0], host_link_model_i.rx_q[1]}, 16'hFF38);
        chk({host_link_model_i.rx_q[2], host_link_model_i.rx_q[3]}, 16'h545A);
        chk(host_link_model_i.rx_q[57], 16'h6C);
        cmd(8'h06, 8'h04, 2, 16'h0101);
        chk({out_format_q, cal_mode_q, yaw_report_q, seen[0], persist_format_q}, 16'h0049);
        wrap_up();
    end
endmodule
